// ### logic/spms_port.sv
// Added by the designer: register access over Avalon-MM and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "spms_params.svh"

// Function
// - slave: select low activates port; miso drives only if direction says output
// - slave: select high resets bit counter and drops partial byte
// - master with select as output: pin is plain output, no effect
// - master with select input pulled low: clear master bit, become slave
// - such a demotion also sets the transfer complete flag
// - interrupt enable with flag and global enable raises the interrupt
// - port enable gates every transfer
// - bit order select one sends lsb first, zero msb first
// - master select bit picks master or slave role
// - clock polarity sets sck idle level and leading edge direction
// - clock phase zero samples leading edge, one samples trailing edge
// - master sck is clock divided by 4,16,64,128 or 2,8,32,64 doubled
// - transfer complete flag sets when a byte completes; read only
// - flag clears on vector or status read then data access
// - data write during transfer sets collision flag; cleared by status read then data access, not by vector
// - status bits five down to one read zero
// - double speed bit is read-write and doubles master sck
// - data write starts transfer; data read returns receive buffer
// - polarity and phase form transfer modes zero to three
// - master write runs eight bits then stops; select not driven
// - single buffered transmit, double buffered receive
// - enabled port drives a pin only where its role and its direction bit both allow
module spms_port (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // avalon-mm slave
   input wire logic [1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // processor side
   input wire logic global_irq_enable_in,
   input wire logic irq_vector_ack_in,
   output logic irq_out,
   // sck pin
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe_out,
   // mosi pin
   input wire logic mosi_in,
   output logic mosi_out,
   output logic mosi_oe_out,
   // miso pin
   input wire logic miso_in,
   output logic miso_out,
   output logic miso_oe_out,
   // slave select pin
   input wire logic ss_n_in,
   output logic ss_n_out,
   output logic ss_oe_out
);
   // software state
   logic [7:0] ctrl_r;
   logic [4:0] pins_r;
   logic dbl_r;
   logic done_flag_r;
   logic write_collision_flag_flag_r;
   logic arm_r;
   // bus state
   logic wait_r;
   logic [7:0] rdata_r;
   // shifter state
   spms_pkg::spms_state_t state_r;
   logic [7:0] shreg_r;
   logic [7:0] rxbuf_r;
   logic [2:0] bit_cnt_r;
   logic [3:0] edge_cnt_r;
   logic sck_r;
   logic out_r;
   logic sck_prev_r;
   // pin and irq flops
   logic irq_r;
   logic sck_oe_r;
   logic mosi_oe_r;
   logic miso_oe_r;
   logic ss_oe_r;

   // decoded controls
   logic en;
   logic master;
   logic lsb_first;
   logic clock_polarity;
   logic clock_phase;
   logic acc;
   logic wr_acc;
   logic rd_acc;
   logic data_acc;
   logic data_wr;
   logic demote;
   logic m_run;
   logic tick;
   logic m_lead;
   logic m_end;
   logic s_act;
   logic s_chg;
   logic s_lead;
   logic samp_ev;
   logic setup_ev;
   logic rx_bit;
   logic tx_bit;
   logic [7:0] shift_nxt;
   logic byte_done;
   logic busy;
   logic start;
   logic done_set;
   logic flag_clr;

   assign en = ctrl_r[`SPMS_B_PORT_EN];
   assign master = ctrl_r[`SPMS_B_MASTER];
   assign lsb_first = ctrl_r[`SPMS_B_LSB_FIRST];
   assign clock_polarity = ctrl_r[`SPMS_B_CLOCK_POLARITY];
   assign clock_phase = ctrl_r[`SPMS_B_CLOCK_PHASE];

   // an access completes at the edge where waitrequest is seen low
   assign acc = (avs_read_in || avs_write_in) && !wait_r;
   assign wr_acc = acc && avs_write_in && avs_byteenable_in[0];
   assign rd_acc = acc && avs_read_in;
   assign data_acc = acc && (avs_address_in == `SPMS_ADR_DATA);
   assign data_wr = wr_acc && (avs_address_in == `SPMS_ADR_DATA);

   // another master pulls our select input low
   assign demote = en && master && !pins_r[`SPMS_B_DIR_SS] && !ss_n_in;

   // master edges come from the divider
   assign m_run = (state_r == spms_pkg::st_run);
   assign m_lead = !edge_cnt_r[0];
   assign m_end = tick && (edge_cnt_r == `SPMS_LAST_EDGE);

   // slave edges: sck is synchronous, one flop of history suffices
   assign s_act = en && !master && !ss_n_in;
   assign s_chg = s_act && (sck_in != sck_prev_r);
   assign s_lead = (sck_prev_r == clock_polarity);

   // leading edge samples when phase is zero, trailing when one
   always_comb begin
      if (master) begin
         samp_ev = m_run && tick && (m_lead ^ clock_phase);
         setup_ev = m_run && tick && !(m_lead ^ clock_phase);
      end else begin
         samp_ev = s_chg && (s_lead ^ clock_phase);
         setup_ev = s_chg && !(s_lead ^ clock_phase);
      end
   end

   // bit order: shift from the chosen end, fill from the other
   assign rx_bit = master ? miso_in : mosi_in;
   assign tx_bit = lsb_first ? shreg_r[0] : shreg_r[7];
   assign shift_nxt = lsb_first ? {rx_bit, shreg_r[7:1]} : {shreg_r[6:0], rx_bit};
   assign byte_done = samp_ev && (bit_cnt_r == `SPMS_LAST_BIT);

   // a slave is busy once its first bit is in
   assign busy = master ? m_run : (bit_cnt_r != 3'h0);
   assign start = data_wr && en && master && !m_run && !demote;

   // master completes on the last edge, slave on the last sample
   assign done_set = (master ? m_end : byte_done) || demote;
   assign flag_clr = data_acc && arm_r;

   spms_rate_div u_div (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .run_in(m_run),
      .rate_in({dbl_r, ctrl_r[1:0]}),
      .tick_out(tick)
   );

   // waitrequest drops for one cycle per request; readdata settles with it
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         wait_r <= 1'b1;
      end else begin
         wait_r <= !((avs_read_in || avs_write_in) && wait_r);
      end
   end

   // read mux snapshot, taken while waitrequest is still high
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         rdata_r <= 8'h00;
      end else if (avs_read_in && wait_r) begin
         case (avs_address_in)
            `SPMS_ADR_CTRL: rdata_r <= ctrl_r;
            `SPMS_ADR_STAT: rdata_r <= {done_flag_r, write_collision_flag_flag_r, 5'h00, dbl_r};
            `SPMS_ADR_DATA: rdata_r <= rxbuf_r;
            `SPMS_ADR_PINS: rdata_r <= {3'h0, pins_r};
            default: rdata_r <= 8'h00;
         endcase
      end
   end

   // control register; demotion overrides a same-cycle write
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         ctrl_r <= `SPMS_CTRL_RST;
      end else begin
         if (wr_acc && (avs_address_in == `SPMS_ADR_CTRL)) begin
            ctrl_r <= avs_writedata_in[7:0];
         end
         if (demote) begin
            ctrl_r[`SPMS_B_MASTER] <= 1'b0;
         end
      end
   end

   // pin directions and select level, as the port's gpio would hold them
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         pins_r <= `SPMS_PINS_RST;
      end else if (wr_acc && (avs_address_in == `SPMS_ADR_PINS)) begin
         pins_r <= avs_writedata_in[4:0];
      end
   end

   // only the double speed bit of status is writable
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         dbl_r <= 1'b0;
      end else if (wr_acc && (avs_address_in == `SPMS_ADR_STAT)) begin
         dbl_r <= avs_writedata_in[`SPMS_B_DBL];
      end
   end

   // arm on a status read that showed a flag, as software saw it
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         arm_r <= 1'b0;
      end else if (rd_acc && (avs_address_in == `SPMS_ADR_STAT)) begin
         arm_r <= rdata_r[`SPMS_B_DONE] || rdata_r[`SPMS_B_WRITE_COLLISION_FLAG];
      end else if (data_acc) begin
         arm_r <= 1'b0;
      end
   end

   // completion flag: a set in the clearing cycle wins
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         done_flag_r <= 1'b0;
      end else begin
         done_flag_r <= done_set || (done_flag_r && !flag_clr && !irq_vector_ack_in);
      end
   end

   // collision flag: write refused while a byte is moving
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         write_collision_flag_flag_r <= 1'b0;
      end else begin
         write_collision_flag_flag_r <= (data_wr && busy) || (write_collision_flag_flag_r && !flag_clr);
      end
   end

   // shift register: loaded only when idle, since transmit is single buffered
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         shreg_r <= `SPMS_DATA_RST;
      end else if (data_wr && !busy) begin
         shreg_r <= avs_writedata_in[7:0];
      end else if (samp_ev) begin
         shreg_r <= shift_nxt;
      end
   end

   // receive buffer holds the last whole byte; an unread one is overwritten
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         rxbuf_r <= `SPMS_DATA_RST;
      end else if (byte_done) begin
         rxbuf_r <= shift_nxt;
      end
   end

   // bit counter, cleared whenever the slave is deselected
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         bit_cnt_r <= 3'h0;
      end else if (!en || demote || start || (!master && ss_n_in)) begin
         bit_cnt_r <= 3'h0;
      end else if (samp_ev) begin
         bit_cnt_r <= bit_cnt_r + 3'h1;
      end
   end

   // master clock generator runs sixteen edges, then stops
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         state_r <= spms_pkg::st_idle;
      end else begin
         case (state_r)
            spms_pkg::st_idle: begin
               if (start) begin
                  state_r <= spms_pkg::st_run;
               end
            end
            spms_pkg::st_run: begin
               if (!en || !master || demote || m_end) begin
                  state_r <= spms_pkg::st_idle;
               end
            end
            default: state_r <= spms_pkg::st_idle;
         endcase
      end
   end

   // edge count within the byte
   always_ff @(posedge ref_clk_in) begin
      if (rst_in || start) begin
         edge_cnt_r <= 4'h0;
      end else if (m_run && tick) begin
         edge_cnt_r <= edge_cnt_r + 4'h1;
      end
   end

   // sck rests at the polarity level between bytes
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         sck_r <= 1'b0;
      end else if (!m_run) begin
         sck_r <= clock_polarity;
      end else if (tick) begin
         sck_r <= !sck_r;
      end
   end

   // serial out: first bit placed at start so it leads the first edge
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         out_r <= 1'b0;
      end else if (start) begin
         out_r <= lsb_first ? avs_writedata_in[0] : avs_writedata_in[7];
      end else if (setup_ev || !busy) begin
         out_r <= tx_bit;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         sck_prev_r <= 1'b0;
      end else begin
         sck_prev_r <= sck_in;
      end
   end

   // port overrides: drives only where role and direction allow
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         sck_oe_r <= 1'b0;
         mosi_oe_r <= 1'b0;
         miso_oe_r <= 1'b0;
         ss_oe_r <= 1'b0;
      end else begin
         sck_oe_r <= en && master && pins_r[`SPMS_B_DIR_SCK];
         mosi_oe_r <= en && master && pins_r[`SPMS_B_DIR_MOSI];
         miso_oe_r <= s_act && pins_r[`SPMS_B_DIR_MISO];
         ss_oe_r <= en && master && pins_r[`SPMS_B_DIR_SS];
      end
   end

   // interrupt request, registered
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= ctrl_r[`SPMS_B_IRQ_EN] && done_flag_r && global_irq_enable_in;
      end
   end

   assign avs_readdata_out = {24'h000000, rdata_r};
   assign avs_waitrequest_out = wait_r;
   assign irq_out = irq_r;
   assign sck_out = sck_r;
   assign sck_oe_out = sck_oe_r;
   assign mosi_out = out_r;
   assign mosi_oe_out = mosi_oe_r;
   assign miso_out = out_r;
   assign miso_oe_out = miso_oe_r;
   // select level is a plain output, no automatic framing
   assign ss_n_out = pins_r[`SPMS_B_SS_LVL];
   assign ss_oe_out = ss_oe_r;
endmodule
`default_nettype wire

// ### logic/spms_rate_div.sv
`timescale 1ns/100ps
`default_nettype none
`include "spms_params.svh"

module spms_rate_div (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // control
   input wire logic run_in,
   input wire logic [2:0] rate_in,
   // one-cycle pulse at each sck half period
   output logic tick_out
);
   logic [6:0] half;
   logic [6:0] cnt_r;

   // rate bits to half period
   always_comb begin
      case (rate_in)
         3'h0: half = `SPMS_HALF_DIV4;
         3'h1: half = `SPMS_HALF_DIV16;
         3'h2: half = `SPMS_HALF_DIV64;
         3'h3: half = `SPMS_HALF_DIV128;
         3'h4: half = `SPMS_HALF_DIV2;
         3'h5: half = `SPMS_HALF_DIV8;
         3'h6: half = `SPMS_HALF_DIV32;
         default: half = `SPMS_HALF_DIV64;
      endcase
   end

   assign tick_out = run_in && (cnt_r == half - 7'h01);

   // count restarts with every byte so edges are evenly spaced
   always_ff @(posedge ref_clk_in) begin
      if (rst_in || !run_in || tick_out) begin
         cnt_r <= 7'h00;
      end else begin
         cnt_r <= cnt_r + 7'h01;
      end
   end
endmodule
`default_nettype wire

// ### shared/spms_params.svh
`ifndef SPMS_PARAMS_SVH
`define SPMS_PARAMS_SVH

// word addresses on the avalon slave (byte address = 4 * index)
`define SPMS_ADR_CTRL 2'h0
`define SPMS_ADR_STAT 2'h1
`define SPMS_ADR_DATA 2'h2
`define SPMS_ADR_PINS 2'h3

// control register fields
`define SPMS_B_IRQ_EN 7
`define SPMS_B_PORT_EN 6
`define SPMS_B_LSB_FIRST 5
`define SPMS_B_MASTER 4
`define SPMS_B_CLOCK_POLARITY 3
`define SPMS_B_CLOCK_PHASE 2

// status register fields
`define SPMS_B_DONE 7
`define SPMS_B_WRITE_COLLISION_FLAG 6
`define SPMS_B_DBL 0

// pin control register fields (direction bits, ss level)
`define SPMS_B_DIR_MOSI 0
`define SPMS_B_DIR_MISO 1
`define SPMS_B_DIR_SCK 2
`define SPMS_B_DIR_SS 3
`define SPMS_B_SS_LVL 4

// reset values
`define SPMS_CTRL_RST 8'h00
`define SPMS_PINS_RST 5'h00
`define SPMS_DATA_RST 8'h00

// sck half periods in ref_clk cycles, index {double, rate_high, rate_low}
`define SPMS_HALF_DIV4 7'h02
`define SPMS_HALF_DIV16 7'h08
`define SPMS_HALF_DIV64 7'h20
`define SPMS_HALF_DIV128 7'h40
`define SPMS_HALF_DIV2 7'h01
`define SPMS_HALF_DIV8 7'h04
`define SPMS_HALF_DIV32 7'h10

// sixteen sck edges per byte, eight samples per byte
`define SPMS_LAST_EDGE 4'hf
`define SPMS_LAST_BIT 3'h7

`endif

// ### shared/spms_pkg.sv
`default_nettype none
package spms_pkg;
   // master clock generator state
   typedef enum logic {st_idle, st_run} spms_state_t;
endpackage
`default_nettype wire

// ### tb/spms_port_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "spms_params.svh"
module spms_port_properties (
   // watched ports
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic [1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   input wire logic global_irq_enable_in,
   input wire logic irq_vector_ack_in,
   input wire logic irq_out,
   input wire logic ss_n_in,
   input wire logic sck_oe_out,
   input wire logic mosi_oe_out,
   input wire logic miso_oe_out,
   input wire logic ss_oe_out
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   // bus answers once per request
   property p_wait_one; !avs_waitrequest_out |=> avs_waitrequest_out; endproperty
   a_wait_one: assert property (p_wait_one) else $error("wait low twice");
   property p_wait_cause;
      !avs_waitrequest_out |-> $past(avs_read_in) || $past(avs_write_in);
   endproperty
   a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
   property p_rd_upper;
      !avs_waitrequest_out && avs_read_in |-> avs_readdata_out[31:8] == 24'h000000;
   endproperty
   a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
   property p_rsv_zero;
      !avs_waitrequest_out && avs_read_in && avs_address_in == `SPMS_ADR_STAT
         |-> avs_readdata_out[5:1] == 5'h00;
   endproperty
   a_rsv_zero: assert property (p_rsv_zero) else $error("reserved status bits set");
   // interrupt needs global enable; vector clears it
   property p_irq_gie; irq_out |-> $past(global_irq_enable_in); endproperty
   a_irq_gie: assert property (p_irq_gie) else $error("irq without global enable");
   property p_ack_clr; irq_vector_ack_in |-> ##2 !irq_out; endproperty
   a_ack_clr: assert property (p_ack_clr) else $error("irq kept after vector");
   // pin roles
   property p_miso_ss; miso_oe_out |-> !$past(ss_n_in); endproperty
   a_miso_ss: assert property (p_miso_ss) else $error("miso driven unselected");
   property p_roles; miso_oe_out |-> !mosi_oe_out && !sck_oe_out && !ss_oe_out; endproperty
   a_roles: assert property (p_roles) else $error("slave drives master pins");
   property p_demote; !ss_n_in && !ss_oe_out && sck_oe_out |-> ##[1:3] !sck_oe_out; endproperty
   a_demote: assert property (p_demote) else $error("master kept after select");
endmodule
bind spms_port spms_port_properties u_props (
   .ref_clk_in(ref_clk_in),
   .rst_in(rst_in),
   .avs_address_in(avs_address_in),
   .avs_read_in(avs_read_in),
   .avs_write_in(avs_write_in),
   .avs_readdata_out(avs_readdata_out),
   .avs_waitrequest_out(avs_waitrequest_out),
   .global_irq_enable_in(global_irq_enable_in),
   .irq_vector_ack_in(irq_vector_ack_in),
   .irq_out(irq_out),
   .ss_n_in(ss_n_in),
   .sck_oe_out(sck_oe_out),
   .mosi_oe_out(mosi_oe_out),
   .miso_oe_out(miso_oe_out),
   .ss_oe_out(ss_oe_out)
);
`default_nettype wire

// ### tb/spms_port_tb.sv
`timescale 1ns/100ps
`default_nettype none
module spms_port_tb;
   logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, gie = 1'b0, ack = 1'b0;
   logic tb_sck = 1'b0, tb_mosi = 1'b0, ss_drv = 1'b1, clock_phase = 1'b0;
   logic [1:0] adr = 2'h0;
   logic [31:0] wdat = 32'h00000000;
   logic [7:0] dev_tx = 8'h00, q, sgot = 8'h00, cnt = 8'h00, half_seen = 8'h00;
   logic [7:0] hexp [8] = '{8'h02, 8'h08, 8'h20, 8'h40, 8'h01, 8'h04, 8'h10, 8'h20};
   logic [3:0] m;
   logic sck_prev = 1'b0;
   int bad_count = 0, n_checks = 0;
   wire [31:0] rdat;
   wire wreq, irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe;
   wire dev_miso;
   wire [7:0] dev_rx;
   // pin levels from whoever drives
   wire sck_w = sck_oe ? sck_o : tb_sck;
   wire mosi_w = mosi_oe ? mosi_o : tb_mosi;
   wire miso_w = miso_oe ? miso_o : dev_miso;
   wire ss_w = ss_oe ? ss_o : ss_drv;
   spms_port DUT (.ref_clk_in(clk), .rst_in(rst), .avs_address_in(adr), .avs_read_in(rd),
      .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(4'hf),
      .avs_readdata_out(rdat), .avs_waitrequest_out(wreq), .global_irq_enable_in(gie),
      .irq_vector_ack_in(ack), .irq_out(irq), .sck_in(sck_w), .sck_out(sck_o),
      .sck_oe_out(sck_oe), .mosi_in(mosi_w), .mosi_out(mosi_o), .mosi_oe_out(mosi_oe),
      .miso_in(miso_w), .miso_out(miso_o), .miso_oe_out(miso_oe), .ss_n_in(ss_w),
      .ss_n_out(ss_o), .ss_oe_out(ss_oe));
   spms_spi_dev u_dev (.clk_in(clk), .sck_in(sck_w), .mosi_in(mosi_w), .ss_n_in(ss_w),
      .miso_out(dev_miso), .clock_phase_in(clock_phase), .tx_in(dev_tx), .rx_out(dev_rx));
   initial begin
      forever #5 clk = ~clk;
   end
   // last sck half period, in clocks
   always @(posedge clk) begin
      sck_prev <= sck_o;
      if (sck_o != sck_prev) begin
         half_seen <= cnt;
         cnt <= 8'h01;
      end else cnt <= cnt + 8'h01;
   end
   function automatic logic [7:0] rv(input logic [7:0] x);
      for (int i = 0; i < 8; i++) rv[i] = x[7 - i];
   endfunction
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one avalon access, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d,
         output logic [7:0] r);
      adr <= a;
      wdat <= {24'h000000, d};
      wr <= w;
      rd <= !w;
      @(posedge clk);
      // only the watchdog ends this wait
      while (wreq !== 1'b0) begin
         @(posedge clk);
      end
      r = rdat[7:0];
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wdone;
      int n;
      n = 0;
      q = 8'h00;
      while (q[7] !== 1'b1 && n < 600) begin
         bus(1'b0, 2'h1, 8'h00, q);
         n++;
      end
      // a poll limit that runs out counts against the run
      chk("done seen", 8'h80, q & 8'h80);
   endtask
   task automatic mxfer(input logic [7:0] c, input logic [7:0] d, input logic [7:0] t,
         input logic ck);
      bus(1'b1, 2'h3, 8'h1d, q);
      dev_tx <= t;
      clock_phase <= c[2];
      // role and polarity settle while the peripheral is still deselected
      bus(1'b1, 2'h0, c, q);
      bus(1'b1, 2'h3, 8'h0d, q);
      bus(1'b1, 2'h2, d, q);
      if (!c[2]) chk("first bit", {7'h00, c[5] ? d[0] : d[7]}, {7'h00, mosi_o});
      wdone;
      chk("done", 8'h80, q & 8'hfe);
      bus(1'b0, 2'h2, 8'h00, q);
      if (ck) chk("rx", c[5] ? rv(t) : t, q);
      chk("dev rx", c[5] ? rv(d) : d, dev_rx);
      chk("sck idle", {7'h00, c[3]}, {7'h00, sck_o});
      bus(1'b0, 2'h1, 8'h00, q);
      chk("flag clr", 8'h00, q & 8'hfe);
   endtask
   // external master, four clocks per sck phase
   task automatic sbyte(input logic [7:0] d, input int nb);
      for (int i = 0; i < nb; i++) begin
         tb_mosi <= d[7 - i];
         repeat (4) @(posedge clk);
         tb_sck <= 1'b1;
         sgot = {sgot[6:0], miso_w};
         repeat (4) @(posedge clk);
         tb_sck <= 1'b0;
      end
      repeat (4) @(posedge clk);
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk);
      bad_count++;
      print_verdict;
   end
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      bus(1'b0, 2'h0, 8'h00, q);
      chk("ctrl reset", 8'h00, q);
      bus(1'b1, 2'h1, 8'hff, q);
      bus(1'b0, 2'h1, 8'h00, q);
      chk("status bits", 8'h01, q);
      bus(1'b1, 2'h1, 8'h00, q);
      // disabled port stays quiet
      bus(1'b1, 2'h3, 8'h0d, q);
      bus(1'b1, 2'h2, 8'h55, q);
      repeat (40) @(posedge clk);
      bus(1'b0, 2'h1, 8'h00, q);
      chk("disabled", 8'h00, q);
      for (m = 0; m < 8; m++) mxfer(8'h50 | {2'h0, m[2], 1'b0, m[1:0], 2'h0},
         8'h3c ^ {m, m}, 8'ha6 ^ {4'h0, m}, 1'b1);
      // all eight rates
      for (m = 0; m < 8; m++) begin
         bus(1'b1, 2'h1, {7'h00, m[2]}, q);
         mxfer({6'h14, m[1:0]}, 8'hc3, 8'h5a, m != 4);
         chk("half period", hexp[m], half_seen);
      end
      bus(1'b1, 2'h1, 8'h00, q);
      bus(1'b1, 2'h0, 8'h50, q);
      // write while busy
      bus(1'b1, 2'h2, 8'h11, q);
      bus(1'b1, 2'h2, 8'h22, q);
      wdone;
      chk("collision", 8'hc0, q);
      bus(1'b0, 2'h2, 8'h00, q);
      chk("kept byte", 8'h11, dev_rx);
      bus(1'b0, 2'h1, 8'h00, q);
      chk("write_collision_flag clr", 8'h00, q);
      // interrupt, then masked by global enable
      gie <= 1'b1;
      bus(1'b1, 2'h0, 8'hd0, q);
      bus(1'b1, 2'h2, 8'h77, q);
      for (int n = 0; n < 300 && irq !== 1'b1; n++) @(posedge clk);
      chk("irq", 8'h01, {7'h00, irq});
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      repeat (2) @(posedge clk);
      chk("irq clr", 8'h00, {7'h00, irq});
      bus(1'b0, 2'h1, 8'h00, q);
      chk("vector clr", 8'h00, q);
      gie <= 1'b0;
      bus(1'b1, 2'h2, 8'h78, q);
      wdone;
      chk("masked", 8'h00, {7'h00, irq});
      bus(1'b0, 2'h2, 8'h00, q);
      // select pulled low while master
      bus(1'b1, 2'h3, 8'h15, q);
      bus(1'b1, 2'h0, 8'h50, q);
      ss_drv <= 1'b0;
      repeat (4) @(posedge clk);
      bus(1'b0, 2'h0, 8'h00, q);
      chk("demoted", 8'h40, q);
      bus(1'b0, 2'h1, 8'h00, q);
      chk("demote flag", 8'h80, q);
      bus(1'b0, 2'h2, 8'h00, q);
      ss_drv <= 1'b1;
      // software restores master role, then hands over to slave
      bus(1'b1, 2'h0, 8'h50, q);
      bus(1'b0, 2'h0, 8'h00, q);
      chk("master back", 8'h50, q);
      bus(1'b1, 2'h0, 8'h40, q);
      // slave: partial byte dropped, then full byte
      bus(1'b1, 2'h3, 8'h02, q);
      bus(1'b1, 2'h2, 8'h96, q);
      ss_drv <= 1'b0;
      sbyte(8'h5b, 3);
      chk("miso bits", 8'h04, sgot & 8'h07);
      ss_drv <= 1'b1;
      repeat (2) @(posedge clk);
      bus(1'b0, 2'h1, 8'h00, q);
      chk("partial", 8'h00, q);
      ss_drv <= 1'b0;
      sbyte(8'ha5, 8);
      ss_drv <= 1'b1;
      wdone;
      bus(1'b0, 2'h2, 8'h00, q);
      chk("slave rx", 8'ha5, q);
      print_verdict;
   end
endmodule
`default_nettype wire

// ### tb/spms_spi_dev.sv
`timescale 1ns/100ps
`default_nettype none
module spms_spi_dev (
   // pins
   input wire logic clk_in,
   input wire logic sck_in,
   input wire logic mosi_in,
   input wire logic ss_n_in,
   output logic miso_out,
   // mode and data
   input wire logic clock_phase_in,
   input wire logic [7:0] tx_in,
   output logic [7:0] rx_out
);
   logic sck_q;
   logic lead;
   logic [7:0] sh;
   // registered peripheral: answers a clock after each seen edge
   always @(posedge clk_in) begin
      sck_q <= sck_in;
      if (ss_n_in) begin
         lead <= 1'b1;
         sh <= tx_in;
         miso_out <= ~sh[7]; // deselected line shows the inverse of the first bit
      end else if (sck_in != sck_q) begin
         lead <= ~lead;
         if (lead != clock_phase_in) begin
            rx_out <= {rx_out[6:0], mosi_in};
            sh <= {sh[6:0], 1'b0};
         end else miso_out <= sh[7];
      end else if (!clock_phase_in && lead) miso_out <= sh[7];
   end
endmodule
`default_nettype wire
